// ===== design/sram_tap_params.svh
// constants of the memory boundary-scan test access port
`ifndef SRAM_TAP_PARAMS_SVH
`define SRAM_TAP_PARAMS_SVH

// ----------------------------------------------------------------------
// register widths
// ----------------------------------------------------------------------
`define TAP_IR_W 3
`define TAP_ID_W 32

// ----------------------------------------------------------------------
// reset and capture values
// ----------------------------------------------------------------------
`define TAP_IR_CAPTURE_BITS 2'b01
`define TAP_BYPASS_CAPTURE 1'b0
`define TAP_TDO_RST 1'b0
`define TAP_TDO_OE_RST 1'b0

// ----------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------
`define TAP_CODE_FLOAT_SAMPLE 3'h0

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define TAP_TMS_RESET_EDGES 5

`endif

// ===== design/sram_tap_pkg.sv
// types of the memory boundary-scan test access port
package sram_tap_pkg;

    // standard sixteen-state controller, DR and IR codes from capture to update differ only in bit 3
    typedef enum logic [3:0] {
        ST_TLR = 4'hf,
        ST_RTI = 4'hc,
        ST_SEL_DR = 4'h7,
        ST_CAP_DR = 4'h6,
        ST_SH_DR = 4'h2,
        ST_EX1_DR = 4'h1,
        ST_PAU_DR = 4'h3,
        ST_EX2_DR = 4'h0,
        ST_UPD_DR = 4'h5,
        ST_SEL_IR = 4'h4,
        ST_CAP_IR = 4'he,
        ST_SH_IR = 4'ha,
        ST_EX1_IR = 4'h9,
        ST_PAU_IR = 4'hb,
        ST_EX2_IR = 4'h8,
        ST_UPD_IR = 4'hd
    } tap_state_t;

    // data register placed between serial in and serial out
    typedef enum logic [1:0] {
        DR_BYPASS = 2'h0,
        DR_IDENT = 2'h1,
        DR_BOUNDARY = 2'h2
    } dr_select_t;

endpackage

// ===== design/sram_boundary_scan_tap.sv
// boundary-scan test access port of a pipelined burst memory
`timescale 1ns/10ps
`include "sram_tap_params.svh"

// Notes on behaviour
// R1 - sample inputs rising, drive outputs falling
// R2 - sample mode select each rise, undriven reads high
// R3 - loaded instruction picks the data register
// R4 - data enters MSB, leaves from LSB
// R5 - serial output driven only while shifting
// R6 - five high mode-select edges reach reset state
// R7 - port reset never disturbs memory operation
// R8 - power-up reset, serial output starts floating
// R9 - at most one register on the path
// R10 - three-bit instruction register loaded serially
// R11 - identification instruction after power-up and reset
// R12 - capture-IR loads 01 into low bits
// R13 - single-bit bypass register path
// R14 - bypass bit cleared when bypass takes effect
// R15 - controller, instruction, boundary, bypass, ident registers
// R16 - unused port keeps test clock low
// R17 - all-zero code samples and floats memory outputs
// R18 - identification code captured then shifted out
// R19 - capture-with-float shifts boundary, floats outputs
// R20 - capture-DR loads memory pin values
// R21 - standard sixteen-state sequence on mode select
// R22 - codes are parameters, reserved selects bypass
// R23 - new instruction effective only at update-IR
module sram_boundary_scan_tap
    import sram_tap_pkg::*;
#(
    parameter int BSR_W = 8,
    parameter logic [2:0] CODE_IDENT = 3'h1,
    parameter logic [2:0] CODE_FLOAT_CAPTURE = 3'h2,
    parameter logic [2:0] CODE_SAMPLE = 3'h4,
    parameter logic [2:0] CODE_BYPASS = 3'h7,
    // arbitrary neutral identification value; lsb kept at one
    parameter logic [31:0] IDENT_VALUE = 32'h0000_0001
) (
    // core clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // serial test port
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    // memory side
    input wire logic [BSR_W-1:0] i_mem_pins,
    output logic o_mem_outputs_float
);
    import sram_tap_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    localparam logic [2:0] CODE_ZERO = `TAP_CODE_FLOAT_SAMPLE;

    // the shift part-select needs at least two boundary cells
    if (BSR_W < 2) begin : g_chk_bsr_w
        $error("boundary register needs at least two bits");
    end
    if (CODE_IDENT == CODE_ZERO || CODE_FLOAT_CAPTURE == CODE_ZERO ||
        CODE_SAMPLE == CODE_ZERO || CODE_BYPASS == CODE_ZERO) begin : g_chk_zero
        $error("the all-zero code is fixed and cannot be reused");
    end
    if (CODE_IDENT == CODE_FLOAT_CAPTURE || CODE_IDENT == CODE_SAMPLE ||
        CODE_IDENT == CODE_BYPASS ||
        CODE_FLOAT_CAPTURE == CODE_SAMPLE ||
        CODE_FLOAT_CAPTURE == CODE_BYPASS ||
        CODE_SAMPLE == CODE_BYPASS) begin : g_chk_distinct
        $error("instruction codes must be distinct");
    end
    if (IDENT_VALUE[0] != 1'b1) begin : g_chk_ident
        $error("identification value must end in one");
    end

    // ------------------------------------------------------------------
    // power-up reset carried into the test clock domain
    // ------------------------------------------------------------------
    // the test clock runs only when a controller drives it, so the
    // reset is seen at the first test clock edges after power-up
    logic tck_rst_meta_reg;
    logic tck_rstn_reg;

    always_ff @(posedge i_tck) begin
        tck_rst_meta_reg <= i_resetn;
        tck_rstn_reg <= tck_rst_meta_reg; // [R8]
    end

    // ------------------------------------------------------------------
    // memory pins carried into the test clock domain
    // ------------------------------------------------------------------
    // pins move far faster than the test clock; a value in transition
    // may be caught either way, but never metastable
    logic [BSR_W-1:0] pin_meta_reg;
    logic [BSR_W-1:0] pin_sync_reg;

    always_ff @(posedge i_tck) begin
        pin_meta_reg <= i_mem_pins;
        pin_sync_reg <= pin_meta_reg;
    end

    // ------------------------------------------------------------------
    // controller state machine
    // ------------------------------------------------------------------
    tap_state_t tap_st_reg;
    tap_state_t tap_st_next;

    // the pad pull-up keeps an open mode-select ball at one
    always_comb begin
        unique case (tap_st_reg) // [R21]
            ST_TLR: tap_st_next = i_tms ? ST_TLR : ST_RTI;
            ST_RTI: tap_st_next = i_tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_st_next = i_tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_st_next = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_st_next = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_st_next = i_tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tap_st_next = i_tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tap_st_next = i_tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_st_next = i_tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_st_next = i_tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: tap_st_next = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_st_next = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_st_next = i_tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: tap_st_next = i_tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: tap_st_next = i_tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_st_next = i_tms ? ST_SEL_DR : ST_RTI;
            default: tap_st_next = ST_TLR;
        endcase
    end

    always_ff @(posedge i_tck) begin
        if (!tck_rstn_reg) begin
            tap_st_reg <= ST_TLR; // [R8]
        end else begin
            tap_st_reg <= tap_st_next; // [R1] [R2] [R6]
        end
    end

    // ------------------------------------------------------------------
    // state decode and register selection
    // ------------------------------------------------------------------
    logic [2:0] ir_shift_reg;
    logic [2:0] instr_reg; // [R15]
    logic bypass_reg;
    logic [31:0] ident_reg;
    logic [BSR_W-1:0] bsr_reg;

    wire in_ir_path = (tap_st_reg == ST_CAP_IR) ||
                      (tap_st_reg == ST_SH_IR) ||
                      (tap_st_reg == ST_EX1_IR) ||
                      (tap_st_reg == ST_PAU_IR) ||
                      (tap_st_reg == ST_EX2_IR);
    wire shifting = (tap_st_reg == ST_SH_DR) || (tap_st_reg == ST_SH_IR);
    wire cap_dr = tap_st_reg == ST_CAP_DR;
    wire sh_dr = tap_st_reg == ST_SH_DR;
    wire is_float = (instr_reg == CODE_ZERO) ||
                    (instr_reg == CODE_FLOAT_CAPTURE);
    wire is_boundary = is_float || (instr_reg == CODE_SAMPLE);

    // reserved codes fall through to bypass
    dr_select_t dr_sel;
    assign dr_sel = (instr_reg == CODE_IDENT) ? DR_IDENT :
                    is_boundary ? DR_BOUNDARY : DR_BYPASS; // [R3] [R9] [R22]

    wire dr_lsb = (dr_sel == DR_IDENT) ? ident_reg[0] :
                  (dr_sel == DR_BOUNDARY) ? bsr_reg[0] : bypass_reg;
    wire path_lsb = in_ir_path ? ir_shift_reg[0] : dr_lsb; // [R4] [R9]

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    always_ff @(posedge i_tck) begin
        if (!tck_rstn_reg || tap_st_reg == ST_TLR) begin
            ir_shift_reg <= CODE_IDENT;
            instr_reg <= CODE_IDENT; // [R11]
        end else if (tap_st_reg == ST_CAP_IR) begin
            ir_shift_reg <= {instr_reg[2], `TAP_IR_CAPTURE_BITS}; // [R12]
        end else if (tap_st_reg == ST_SH_IR) begin
            ir_shift_reg <= {i_tdi, ir_shift_reg[2:1]}; // [R10] [R4]
        end else if (tap_st_reg == ST_UPD_IR) begin
            instr_reg <= ir_shift_reg; // [R23]
        end
    end

    // ------------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_tck) begin
        if (!tck_rstn_reg) begin
            bypass_reg <= `TAP_BYPASS_CAPTURE;
        end else if (cap_dr && dr_sel == DR_BYPASS) begin
            bypass_reg <= `TAP_BYPASS_CAPTURE; // [R14]
        end else if (sh_dr && dr_sel == DR_BYPASS) begin
            bypass_reg <= i_tdi; // [R13]
        end
    end

    always_ff @(posedge i_tck) begin
        if (!tck_rstn_reg) begin
            ident_reg <= IDENT_VALUE;
        end else if (cap_dr && dr_sel == DR_IDENT) begin
            ident_reg <= IDENT_VALUE; // [R18]
        end else if (sh_dr && dr_sel == DR_IDENT) begin
            ident_reg <= {i_tdi, ident_reg[31:1]}; // [R18] [R4]
        end
    end

    // no preload stage: the boundary cells only capture, so nothing
    // shifted in ever reaches the memory pins
    always_ff @(posedge i_tck) begin
        if (!tck_rstn_reg) begin
            bsr_reg <= '0;
        end else if (cap_dr && dr_sel == DR_BOUNDARY) begin
            bsr_reg <= pin_sync_reg; // [R20] [R17]
        end else if (sh_dr && dr_sel == DR_BOUNDARY) begin
            bsr_reg <= {i_tdi, bsr_reg[BSR_W-1:1]}; // [R4] [R19]
        end
    end

    // ------------------------------------------------------------------
    // serial output on the falling edge
    // ------------------------------------------------------------------
    always_ff @(negedge i_tck) begin
        if (!tck_rstn_reg) begin
            o_tdo <= `TAP_TDO_RST;
            o_tdo_oe <= `TAP_TDO_OE_RST; // [R8]
        end else begin
            o_tdo <= path_lsb; // [R1]
            o_tdo_oe <= shifting; // [R5]
        end
    end

    // ------------------------------------------------------------------
    // memory output float request into the core domain
    // ------------------------------------------------------------------
    // this level is the only path into the memory; the port's own
    // reset reselects identification and drops any float request
    logic float_tck_reg;
    logic float_meta_reg;

    // follows the instruction on the same edge: the test clock may be
    // parked right after update-IR, so no later edge can be relied on
    wire upd_float = (ir_shift_reg == CODE_ZERO) ||
                     (ir_shift_reg == CODE_FLOAT_CAPTURE);

    always_ff @(posedge i_tck) begin
        if (!tck_rstn_reg || tap_st_reg == ST_TLR) begin
            float_tck_reg <= 1'b0; // [R7]
        end else if (tap_st_reg == ST_UPD_IR) begin
            float_tck_reg <= upd_float; // [R17] [R19]
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            float_meta_reg <= 1'b0;
            o_mem_outputs_float <= 1'b0;
        end else begin
            float_meta_reg <= float_tck_reg;
            o_mem_outputs_float <= float_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_tms_reset;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        i_tms [*5] |=> tap_st_reg == ST_TLR;
    endproperty
    a_tms_reset: assert property (p_tms_reset) // [R6]
        else $error("five high mode-select edges missed reset");

    property p_capture_ir;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        tap_st_reg == ST_CAP_IR |=> ir_shift_reg[1:0] == 2'b01;
    endproperty
    a_capture_ir: assert property (p_capture_ir) // [R12]
        else $error("capture-IR pattern wrong");

    property p_ident_after_reset;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        tap_st_reg == ST_TLR |=> instr_reg == CODE_IDENT;
    endproperty
    a_ident_after_reset: assert property (p_ident_after_reset) // [R11]
        else $error("instruction not identification after reset");

    property p_update_ir;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        tap_st_reg == ST_UPD_IR |=> instr_reg == $past(ir_shift_reg);
    endproperty
    a_update_ir: assert property (p_update_ir) // [R23]
        else $error("update-IR did not load the shifted code");

    property p_ir_stable;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        tap_st_reg == ST_SH_IR |=> $stable(instr_reg);
    endproperty
    a_ir_stable: assert property (p_ir_stable) // [R23]
        else $error("instruction changed while shifting");

    property p_bypass_clear;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        cap_dr && dr_sel == DR_BYPASS |=> !bypass_reg;
    endproperty
    a_bypass_clear: assert property (p_bypass_clear) // [R14]
        else $error("bypass bit not cleared on capture");

    property p_ident_shift;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        cap_dr && dr_sel == DR_IDENT ##1 sh_dr |=>
            ident_reg == {$past(i_tdi), IDENT_VALUE[31:1]};
    endproperty
    a_ident_shift: assert property (p_ident_shift) // [R18]
        else $error("identification code not shifted toward lsb");

    property p_tdo_enable;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        $past(tck_rstn_reg) |-> o_tdo_oe == shifting;
    endproperty
    a_tdo_enable: assert property (p_tdo_enable) // [R5]
        else $error("serial output enable outside shift states");

    property p_tdo_value;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        o_tdo_oe |-> o_tdo == path_lsb;
    endproperty
    a_tdo_value: assert property (p_tdo_value) // [R1] [R4]
        else $error("serial output not the selected lsb");

    property p_bsr_msb;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        sh_dr && dr_sel == DR_BOUNDARY |=>
            bsr_reg[BSR_W-1] == $past(i_tdi);
    endproperty
    a_bsr_msb: assert property (p_bsr_msb) // [R4]
        else $error("serial input did not enter the msb");

    property p_float_level;
        @(posedge i_tck) disable iff (!tck_rstn_reg)
        $past(tck_rstn_reg) |-> float_tck_reg == is_float;
    endproperty
    a_float_level: assert property (p_float_level) // [R17] [R19]
        else $error("float request missing for floating code");

endmodule

// ===== dv/scan_ctrl_model.sv
// external scan controller model driving the serial test port
`timescale 1ns/10ps
module scan_ctrl_model (
    // serial test port
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo,
    input wire logic i_tdo_oe
);
    // 125 ns period, phase set by the caller
    localparam realtime HALF_PERIOD = 62.5;

    initial begin
        o_tck = 1'h0; // parked low outside frames
        o_tms = 1'h1;
        o_tdi = 1'h1;
    end

    // ------------------------------------------------------------------
    // one test clock period, answer taken at the rise
    // ------------------------------------------------------------------
    task automatic step(input logic tms_v, input logic tdi_v,
            output logic tdo_v, output logic oe_v);
        o_tms = tms_v;
        o_tdi = tdi_v;
        #HALF_PERIOD;
        o_tck = 1'h1;
        tdo_v = i_tdo;
        oe_v = i_tdo_oe;
        #HALF_PERIOD;
        o_tck = 1'h0;
    endtask

    // ends in run-test-idle
    task automatic tap_reset();
        logic d;
        logic e;
        repeat (6) step(1'h1, 1'h1, d, e); // five high edges and more
        step(1'h0, 1'h1, d, e);
    endtask

    // ------------------------------------------------------------------
    // full scan from idle back to idle, lsb first
    // ------------------------------------------------------------------
    task automatic scan(input logic is_ir, input int n,
            input logic [31:0] din, output logic [31:0] dout,
            output logic oe_on, output logic oe_off);
        logic d;
        logic e;
        dout = '0;
        oe_on = 1'h1;
        step(1'h1, 1'h1, d, e);
        if (is_ir) begin
            step(1'h1, 1'h1, d, e);
        end
        step(1'h0, 1'h1, d, e);
        step(1'h0, 1'h1, d, e);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], d, e);
            dout[i] = d;
            oe_on = oe_on & e;
        end
        step(1'h1, 1'h1, d, e);
        oe_off = e;
        step(1'h0, 1'h1, d, e);
    endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench of the boundary-scan test access port
`timescale 1ns/10ps
module tb_top;
    // arbitrary identification value, lsb kept at one
    localparam logic [31:0] ID_VAL = 32'h5a3c_9e01;

    logic core_clk;
    logic resetn;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [7:0] mem_pins;
    logic mem_float;
    logic [31:0] got;
    logic oe_on;
    logic oe_off;
    logic [2:0] prev;
    logic [2:0] codes [4];
    int err_total;
    int samples_checked;

    sram_boundary_scan_tap #(
        .BSR_W(8),
        .IDENT_VALUE(ID_VAL)
    ) i_sram_boundary_scan_tap (
        .i_core_clk(core_clk),
        .i_resetn(resetn),
        .i_tck(tck),
        .i_tms(tms),
        .i_tdi(tdi),
        .o_tdo(tdo),
        .o_tdo_oe(tdo_oe),
        .i_mem_pins(mem_pins),
        .o_mem_outputs_float(mem_float)
    );

    scan_ctrl_model i_scan_ctrl_model (
        .o_tck(tck),
        .o_tms(tms),
        .o_tdi(tdi),
        .i_tdo(tdo),
        .i_tdo_oe(tdo_oe)
    );

    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: %s seen %h expected %h", $time, what,
                seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // loads a code and checks what capture put in the low bits
    task automatic ir_load(input logic [2:0] code);
        i_scan_ctrl_model.scan(1'h1, 3, {29'h0, code}, got, oe_on, oe_off);
        check(got, {29'h0, prev[2], 2'h1}, "ir capture");
        check(32'(oe_on), 32'h1, "tdo enable in shift");
        check(32'(oe_off), 32'h0, "tdo enable after shift");
        prev = code;
        // float level crosses into the core domain
        repeat (8) @(posedge core_clk);
    endtask

    task automatic dr_scan(input int n, input logic [31:0] din);
        i_scan_ctrl_model.scan(1'h0, n, din, got, oe_on, oe_off);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'h0;
        mem_pins = 8'h00;
        err_total = 0;
        samples_checked = 0;
        prev = 3'h1;
        codes = '{3'h7, 3'h3, 3'h5, 3'h6};
        #3;
        // test clock must run while the port sees reset
        fork
            repeat (16) @(posedge core_clk);
            i_scan_ctrl_model.tap_reset();
        join
        @(posedge core_clk);
        resetn <= 1'h1;
        mem_pins <= 8'ha5;
        i_scan_ctrl_model.tap_reset();
        // let the falling-edge update settle before looking
        @(posedge core_clk);
        check(32'(tdo_oe), 32'h0, "tdo floats after reset");
        check(32'(mem_float), 32'h0, "float after reset");
        dr_scan(32, 32'h0f0f_3c3c);
        check(got, ID_VAL, "ident after reset");
        check(32'(oe_on), 32'h1, "tdo enable in dr shift");
        // bypass and reserved codes give a one-stage path
        foreach (codes[k]) begin
            ir_load(codes[k]);
            dr_scan(8, 32'h0000_00b4);
            check(got, 32'h0000_0068, "bypass path");
        end
        ir_load(3'h4);
        check(32'(mem_float), 32'h0, "sample keeps outputs");
        dr_scan(8, 32'h0000_003c);
        check(got, 32'h0000_00a5, "sample capture");
        @(posedge core_clk);
        mem_pins <= 8'h5a;
        ir_load(3'h2);
        check(32'(mem_float), 32'h1, "capture float");
        dr_scan(8, 32'h0000_00ff);
        check(got, 32'h0000_005a, "float capture data");
        ir_load(3'h0);
        check(32'(mem_float), 32'h1, "all-zero float");
        dr_scan(8, 32'h0000_0000);
        check(got, 32'h0000_005a, "all-zero capture");
        i_scan_ctrl_model.tap_reset();
        repeat (8) @(posedge core_clk);
        check(32'(mem_float), 32'h0, "float after port reset");
        dr_scan(32, 32'h0000_0000);
        check(got, ID_VAL, "ident after port reset");
        prev = 3'h1;
        ir_load(3'h4);
        test_done();
    end

    // whole run is under two thousand core cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        err_total++;
        test_done();
    end
endmodule
